// file: verilog/ssp_slave_port.sv
// Synchronous slave serial port: the shift clock comes from an external master; data is received from it or sent to it.
// Assumes an AXI4-Lite master on clk; pin inputs are asynchronous to clk.
//
// The register offsets and the AXI4-Lite slave port were decided locally.

module ssp_slave_port #(
    parameter int ADDR_W     = 8,
    parameter int FIFO_DEPTH = 2
) (
    input  wire logic              clk,
    input  wire logic              srst,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic              cpu_sleep,
    input  wire logic              clock_pin_in,
    output logic                   clock_pin_out,
    output logic                   clock_pin_oe,
    input  wire logic              data_pin_in,
    output logic                   data_pin_out,
    output logic                   data_pin_oe,
    output logic                   wake,
    output logic                   irq,
    output logic [11:0]            isr_addr
);

    function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
        is_mapped = (a == ADDR_W'(ssp_pkg::OFS_TX_STATUS)) || (a == ADDR_W'(ssp_pkg::OFS_RX_STATUS))
                 || (a == ADDR_W'(ssp_pkg::OFS_TX_DATA))   || (a == ADDR_W'(ssp_pkg::OFS_RX_DATA))
                 || (a == ADDR_W'(ssp_pkg::OFS_BAUD))      || (a == ADDR_W'(ssp_pkg::OFS_IRQ));
    endfunction

    // Pin synchronisers and stable levels
    logic [2:0] ck_s_r;
    logic [2:0] dt_s_r;
    logic       ck_lvl_r;

    // Bus slave state
    logic              awready_r;
    logic              wready_r;
    logic              bvalid_r;
    logic [1:0]        bresp_r;
    logic              aw_held_r;
    logic              w_held_r;
    logic [ADDR_W-1:0] awaddr_r;
    logic [7:0]        wdata_r;
    logic              wstrb_r;
    logic              arready_r;
    logic              rvalid_r;
    logic [1:0]        rresp_r;
    logic [31:0]       rdata_r;

    // Configuration
    logic [7:0] txs_r;
    logic [7:0] rxs_r;
    logic [7:0] baud_r;
    logic [7:0] irqen_r;

    // Transmit path
    ssp_pkg::ssp_tx_state_t tx_state_r;
    ssp_pkg::ssp_char_t     hold_r;
    logic                   hold_full_r;
    logic [8:0]             tsr_r;
    logic [3:0]             tx_cnt_r;
    logic                   dt_out_r;
    logic                   dt_oe_r;

    // Receive path
    logic [8:0]         rsr_r;
    logic [3:0]         rx_cnt_r;
    ssp_pkg::ssp_char_t fifo_r [FIFO_DEPTH];
    logic [1:0]         fifo_cnt_r;
    logic               overrun_error_r;

    logic wake_r;
    logic irq_r;
    logic [11:0] isr_addr_r;

    // Derived controls
    logic ck_stable;
    logic lead_edge;
    logic trail_edge;
    logic port_en;
    logic slave;
    logic rx_sel;
    logic tx_mode;
    logic rx_on;
    logic aw_hs;
    logic w_hs;
    logic ar_hs;
    logic wr_fire;
    logic wr_txdata;
    logic rd_pop;
    logic tx_done;
    logic tx_load;
    logic [3:0] rx_bits;
    logic rx_done;
    ssp_pkg::ssp_char_t rx_char;
    logic [1:0] cnt_after;
    logic tx_buffer_empty_flag;
    logic rx_char_available_flag;
    logic irq_ev;
    logic [31:0] rd_val;

    assign ck_stable  = ck_s_r[1] == ck_s_r[2];
    // Polarity bit picks which pin edge is the leading one
    assign lead_edge  = ck_stable && (ck_s_r[2] != ck_lvl_r)
                     && (ck_s_r[2] != baud_r[ssp_pkg::BAUD_CK_POL]);
    assign trail_edge = ck_stable && (ck_s_r[2] != ck_lvl_r)
                     && (ck_s_r[2] == baud_r[ssp_pkg::BAUD_CK_POL]);
    assign port_en = rxs_r[ssp_pkg::RXS_PORT_EN];
    assign slave   = txs_r[ssp_pkg::TXS_SYNC] && !txs_r[ssp_pkg::TXS_CLK_SRC] && port_en;
    assign rx_sel  = rxs_r[ssp_pkg::RXS_SINGLE] || rxs_r[ssp_pkg::RXS_CONT];
    assign tx_mode = slave && !rx_sel && txs_r[ssp_pkg::TXS_TX_EN];
    // Either enable receives continuously; no single-shot stop in slave mode
    assign rx_on   = slave && rx_sel && !overrun_error_r;
    assign aw_hs   = s_axi_awvalid && awready_r;
    assign w_hs    = s_axi_wvalid && wready_r;
    assign ar_hs   = s_axi_arvalid && arready_r;
    assign wr_fire = aw_held_r && w_held_r && !bvalid_r;
    assign wr_txdata = wr_fire && wstrb_r && (awaddr_r == ADDR_W'(ssp_pkg::OFS_TX_DATA));
    assign rd_pop  = ar_hs && (s_axi_araddr == ADDR_W'(ssp_pkg::OFS_RX_DATA)) && (fifo_cnt_r != 2'h0);
    assign tx_done = (tx_state_r == ssp_pkg::SSP_TX_SHIFT) && trail_edge && (tx_cnt_r == 4'h0);
    assign tx_load = tx_mode && hold_full_r
                  && ((tx_state_r == ssp_pkg::SSP_TX_IDLE) || tx_done);
    assign rx_bits = rxs_r[ssp_pkg::RXS_NINE] ? ssp_pkg::BITS_9 : ssp_pkg::BITS_8;
    assign rx_done = rx_on && trail_edge && (rx_cnt_r == rx_bits - 4'h1);
    // Bits arrive LSB first at the top of the shifter; 8-bit words sit one place high
    assign rx_char = rxs_r[ssp_pkg::RXS_NINE] ? {dt_s_r[2], rsr_r[8:1]}
                                              : {1'b0, dt_s_r[2], rsr_r[8:2]};
    assign cnt_after = fifo_cnt_r - {1'b0, rd_pop};
    assign tx_buffer_empty_flag   = !hold_full_r;
    assign rx_char_available_flag   = fifo_cnt_r != 2'h0;
    assign irq_ev = irqen_r[ssp_pkg::IRQ_PERIPH]
                 && ((tx_buffer_empty_flag && irqen_r[ssp_pkg::IRQ_TX_EN]) || (rx_char_available_flag && irqen_r[ssp_pkg::IRQ_RX_EN]));

    // The first stage feeds only the second; edges are judged on stages two and three
    always_ff @(posedge clk) begin
        if (srst) begin
            ck_s_r   <= 3'h0;
            dt_s_r   <= 3'h0;
            ck_lvl_r <= 1'b0;
        end else begin
            ck_s_r <= {ck_s_r[1:0], clock_pin_in};
            dt_s_r <= {dt_s_r[1:0], data_pin_in};
            if (ck_stable) begin
                ck_lvl_r <= ck_s_r[2];
            end
        end
    end

    // Write channel: address and data taken in either order, response after both
    always_ff @(posedge clk) begin
        if (srst) begin
            awready_r <= 1'b0;
            wready_r  <= 1'b0;
            bvalid_r  <= 1'b0;
            bresp_r   <= ssp_pkg::RESP_OKAY;
            aw_held_r <= 1'b0;
            w_held_r  <= 1'b0;
            awaddr_r  <= '0;
            wdata_r   <= 8'h00;
            wstrb_r   <= 1'b0;
        end else begin
            awready_r <= !(aw_held_r || aw_hs || bvalid_r);
            wready_r  <= !(w_held_r || w_hs || bvalid_r);
            if (aw_hs) begin
                aw_held_r <= 1'b1;
                awaddr_r  <= s_axi_awaddr;
            end
            if (w_hs) begin
                w_held_r <= 1'b1;
                wdata_r  <= s_axi_wdata[7:0];
                wstrb_r  <= s_axi_wstrb[0];
            end
            if (wr_fire) begin
                aw_held_r <= 1'b0;
                w_held_r  <= 1'b0;
                bvalid_r  <= 1'b1;
                bresp_r   <= is_mapped(awaddr_r) ? ssp_pkg::RESP_OKAY : ssp_pkg::RESP_SLVERR;
            end else if (bvalid_r && s_axi_bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    // Read data view of the register file
    always_comb begin
        rd_val = 32'h0;
        case (s_axi_araddr)
            ADDR_W'(ssp_pkg::OFS_TX_STATUS): begin
                rd_val[7:0] = txs_r;
                rd_val[ssp_pkg::TXS_SHIFT_MT] = tx_state_r == ssp_pkg::SSP_TX_IDLE;
            end
            ADDR_W'(ssp_pkg::OFS_RX_STATUS): begin
                rd_val[7:0] = rxs_r;
                rd_val[ssp_pkg::RXS_OVERRUN] = overrun_error_r;
                rd_val[ssp_pkg::RXS_NINTH] = rxs_r[ssp_pkg::RXS_NINE] && fifo_r[0].ninth;
            end
            ADDR_W'(ssp_pkg::OFS_TX_DATA): begin
                rd_val[7:0] = hold_r.data;
            end
            ADDR_W'(ssp_pkg::OFS_RX_DATA): begin
                rd_val[7:0] = fifo_r[0].data;
            end
            ADDR_W'(ssp_pkg::OFS_BAUD): begin
                rd_val[7:0] = baud_r;
                rd_val[ssp_pkg::BAUD_RX_IDLE] = rx_cnt_r == 4'h0;
            end
            ADDR_W'(ssp_pkg::OFS_IRQ): begin
                rd_val[7:0] = irqen_r;
                rd_val[ssp_pkg::IRQ_TX_FLAG] = tx_buffer_empty_flag;
                rd_val[ssp_pkg::IRQ_RX_FLAG] = rx_char_available_flag;
            end
            default: begin
                rd_val = 32'h0;
            end
        endcase
    end

    // Read channel: one read in flight, data registered when the address is taken
    always_ff @(posedge clk) begin
        if (srst) begin
            arready_r <= 1'b0;
            rvalid_r  <= 1'b0;
            rresp_r   <= ssp_pkg::RESP_OKAY;
            rdata_r   <= 32'h0;
        end else begin
            arready_r <= !(rvalid_r || ar_hs);
            if (ar_hs) begin
                rvalid_r <= 1'b1;
                rdata_r  <= rd_val;
                rresp_r  <= is_mapped(s_axi_araddr) ? ssp_pkg::RESP_OKAY : ssp_pkg::RESP_SLVERR;
            end else if (rvalid_r && s_axi_rready) begin
                rvalid_r <= 1'b0;
            end
        end
    end

    // Software-written configuration
    always_ff @(posedge clk) begin
        if (srst) begin
            txs_r   <= ssp_pkg::REG_RESET;
            rxs_r   <= ssp_pkg::REG_RESET;
            baud_r  <= ssp_pkg::REG_RESET;
            irqen_r <= ssp_pkg::REG_RESET;
        end else if (wr_fire && wstrb_r) begin
            case (awaddr_r)
                ADDR_W'(ssp_pkg::OFS_TX_STATUS): txs_r   <= wdata_r & ssp_pkg::TXS_WMASK;
                ADDR_W'(ssp_pkg::OFS_RX_STATUS): rxs_r   <= wdata_r & ssp_pkg::RXS_WMASK;
                ADDR_W'(ssp_pkg::OFS_BAUD):      baud_r  <= wdata_r & ssp_pkg::BAUD_WMASK;
                ADDR_W'(ssp_pkg::OFS_IRQ):       irqen_r <= wdata_r & ssp_pkg::IRQ_WMASK;
                default: begin
                end
            endcase
        end
    end

    // Holding register: a write in the same cycle as a transfer keeps it full
    always_ff @(posedge clk) begin
        if (srst || !port_en) begin
            hold_r      <= '0;
            hold_full_r <= 1'b0;
        end else if (wr_txdata) begin
            hold_r.data  <= wdata_r;
            hold_r.ninth <= txs_r[ssp_pkg::TXS_NINTH];
            hold_full_r  <= 1'b1;
        end else if (tx_load) begin
            hold_full_r <= 1'b0;
        end
    end

    // Transmit shifter, advanced only by external clock edges; sleep does not stop it
    always_ff @(posedge clk) begin
        if (srst || !port_en) begin
            tx_state_r <= ssp_pkg::SSP_TX_IDLE;
            tsr_r      <= 9'h000;
            tx_cnt_r   <= 4'h0;
            dt_out_r   <= 1'b0;
        end else if (tx_load) begin
            tsr_r      <= txs_r[ssp_pkg::TXS_NINE] ? hold_r : {1'b0, hold_r.data};
            tx_cnt_r   <= txs_r[ssp_pkg::TXS_NINE] ? ssp_pkg::BITS_9 : ssp_pkg::BITS_8;
            tx_state_r <= ssp_pkg::SSP_TX_SHIFT;
        end else if (!tx_mode || tx_done) begin
            tx_state_r <= ssp_pkg::SSP_TX_IDLE;
        end else if (tx_state_r == ssp_pkg::SSP_TX_SHIFT && lead_edge && tx_cnt_r != 4'h0) begin
            dt_out_r <= tsr_r[0];
            tsr_r    <= {1'b0, tsr_r[8:1]};
            tx_cnt_r <= tx_cnt_r - 4'h1;
        end
    end

    // Pin drivers; the clock pin is never driven in slave operation
    always_ff @(posedge clk) begin
        if (srst) begin
            dt_oe_r <= 1'b0;
        end else begin
            dt_oe_r <= tx_mode;
        end
    end

    // Receive shifter; a partial character is dropped when reception stops
    always_ff @(posedge clk) begin
        if (srst || !rx_on) begin
            rsr_r    <= 9'h000;
            rx_cnt_r <= 4'h0;
        end else if (rx_done) begin
            rx_cnt_r <= 4'h0;
        end else if (trail_edge) begin
            rsr_r    <= {dt_s_r[2], rsr_r[8:1]};
            rx_cnt_r <= rx_cnt_r + 4'h1;
        end
    end

    // Two-entry receive buffer, entry 0 is the top
    always_ff @(posedge clk) begin
        if (srst || !port_en) begin
            fifo_cnt_r <= 2'h0;
            for (int i = 0; i < FIFO_DEPTH; i++) begin
                fifo_r[i] <= '0;
            end
        end else begin
            if (rd_pop) begin
                for (int i = 0; i < FIFO_DEPTH - 1; i++) begin
                    fifo_r[i] <= fifo_r[i+1];
                end
            end
            if (rx_done && cnt_after != 2'(FIFO_DEPTH)) begin
                fifo_r[cnt_after[0]] <= rx_char;
                fifo_cnt_r <= cnt_after + 2'h1;
            end else begin
                fifo_cnt_r <= cnt_after;
            end
        end
    end

    // Overrun: set wins over the continuous-enable clear in the same cycle; reset and port disable win over set
    always_ff @(posedge clk) begin
        if (srst || !port_en) begin
            overrun_error_r <= 1'b0;
        end else if (rx_done && cnt_after == 2'(FIFO_DEPTH)) begin
            overrun_error_r <= 1'b1;
        end else if (!rxs_r[ssp_pkg::RXS_CONT]) begin
            overrun_error_r <= 1'b0;
        end
    end

    // Wake and interrupt requests toward the processor
    always_ff @(posedge clk) begin
        if (srst) begin
            wake_r     <= 1'b0;
            irq_r      <= 1'b0;
            isr_addr_r <= 12'h000;
        end else begin
            wake_r     <= cpu_sleep && irq_ev;
            irq_r      <= irq_ev && irqen_r[ssp_pkg::IRQ_GLOBAL];
            isr_addr_r <= (irq_ev && irqen_r[ssp_pkg::IRQ_GLOBAL]) ? ssp_pkg::ISR_VECTOR
                                                                   : 12'h000;
        end
    end

    assign s_axi_awready = awready_r;
    assign s_axi_wready  = wready_r;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rresp   = rresp_r;
    assign s_axi_rdata   = rdata_r;
    assign clock_pin_out = 1'b0;
    assign clock_pin_oe  = 1'b0;
    assign data_pin_out  = dt_out_r;
    assign data_pin_oe   = dt_oe_r;
    assign wake          = wake_r;
    assign irq           = irq_r;
    assign isr_addr      = isr_addr_r;

endmodule

// file: pkg/ssp_pkg.sv
// Shared constants, register map and types for the synchronous slave serial port.
// Assumes a 32-bit AXI4-Lite register bus with byte addresses and a 40 MHz clock.
package ssp_pkg;

    // Register byte offsets
    localparam logic [7:0] OFS_TX_STATUS  = 8'h00;
    localparam logic [7:0] OFS_RX_STATUS  = 8'h04;
    localparam logic [7:0] OFS_TX_DATA    = 8'h08;
    localparam logic [7:0] OFS_RX_DATA    = 8'h0c;
    localparam logic [7:0] OFS_BAUD       = 8'h10;
    localparam logic [7:0] OFS_IRQ        = 8'h14;

    // transmit_status_control fields
    localparam int TXS_CLK_SRC  = 7;
    localparam int TXS_NINE     = 6;
    localparam int TXS_TX_EN    = 5;
    localparam int TXS_SYNC     = 4;
    localparam int TXS_SHIFT_MT = 1;
    localparam int TXS_NINTH    = 0;
    localparam logic [7:0] TXS_WMASK = 8'hf1;

    // receive_status_control fields
    localparam int RXS_PORT_EN  = 7;
    localparam int RXS_NINE     = 6;
    localparam int RXS_SINGLE   = 5;
    localparam int RXS_CONT     = 4;
    localparam int RXS_OVERRUN  = 1;
    localparam int RXS_NINTH    = 0;
    localparam logic [7:0] RXS_WMASK = 8'hf0;

    // baud_control fields
    localparam int BAUD_RX_IDLE = 6;
    localparam int BAUD_CK_POL  = 4;
    localparam logic [7:0] BAUD_WMASK = 8'h10;

    // Interrupt enable and flag register
    localparam int IRQ_TX_EN    = 0;
    localparam int IRQ_RX_EN    = 1;
    localparam int IRQ_PERIPH   = 2;
    localparam int IRQ_GLOBAL   = 3;
    localparam int IRQ_TX_FLAG  = 4;
    localparam int IRQ_RX_FLAG  = 5;
    localparam logic [7:0] IRQ_WMASK = 8'h0f;

    localparam logic [7:0]  REG_RESET   = 8'h00;
    localparam logic [3:0]  BITS_8      = 4'h8;
    localparam logic [3:0]  BITS_9      = 4'h9;
    localparam logic [11:0] ISR_VECTOR  = 12'h004;
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic       ninth;
        logic [7:0] data;
    } ssp_char_t;

    typedef enum logic [0:0] {
        SSP_TX_IDLE  = 1'b0,
        SSP_TX_SHIFT = 1'b1
    } ssp_tx_state_t;

endpackage

// file: testbench/ssp_slave_port_asserts.sv
// Checker for the slave serial port: bus handshakes and event outputs.
// Bound to the top module and sees only its ports.
module ssp_slave_port_asserts (
    input wire logic        clk,
    input wire logic        srst,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        cpu_sleep,
    input wire logic        clock_pin_oe,
    input wire logic        wake,
    input wire logic        irq,
    input wire logic [11:0] isr_addr
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    sequence s_rd_hs; s_axi_arvalid && s_axi_arready; endsequence
    sequence s_wr_hs; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
    property p_rd_ans; s_rd_hs |=> s_axi_rvalid; endproperty
    a_rd_ans: assert property (p_rd_ans) else $error("read answer missing");
    property p_wr_ans; s_wr_hs |=> ##1 s_axi_bvalid; endproperty
    a_wr_ans: assert property (p_wr_ans) else $error("write answer missing");
    property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
    a_r_hold: assert property (p_r_hold) else $error("read data dropped early");
    property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
    a_b_hold: assert property (p_b_hold) else $error("write answer dropped early");
    property p_b_refuse; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
    a_b_refuse: assert property (p_b_refuse) else $error("write taken while answering");
    property p_ck_oe; clock_pin_oe == 1'b0; endproperty
    a_ck_oe: assert property (p_ck_oe) else $error("clock pin driven");
    property p_isr; irq |-> isr_addr == 12'h004; endproperty
    a_isr: assert property (p_isr) else $error("vector wrong");
    property p_isr_off; !irq |-> isr_addr == 12'h000; endproperty
    a_isr_off: assert property (p_isr_off) else $error("vector without event");
    property p_wake; wake |-> $past(cpu_sleep); endproperty
    a_wake: assert property (p_wake) else $error("wake while awake");
    property p_rd_hi; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000; endproperty
    a_rd_hi: assert property (p_rd_hi) else $error("upper read bits set");
endmodule

// file: testbench/ssp_master_model.sv
// External synchronous master: makes the shift clock, drives or samples data.
// Idle clock level follows the polarity set by set_pol; the leading edge leaves it.
module ssp_master_model (
    input wire logic pin,
    output logic     ck,
    output logic     dt
);
    timeunit 1ns;
    timeprecision 100ps;
    logic pol = 1'b0;
    initial begin
        ck = 1'b0; // clock stands still between frames
        dt = 1'b0;
    end
    // Change only while the port cannot shift, since the level change is a pin edge
    task automatic set_pol(input logic p);
        pol = p;
        #7 ck = p;
    endtask
    task automatic xfer(input logic [8:0] d, input int n, output logic [8:0] q);
        q = 9'h000;
        #7;
        for (int i = 0; i < n; i++) begin
            ck = ~pol;
            dt = d[i]; // changes on leading edge, LSB first
            #100 ck = pol;
            q[i] = pin; // sampled at the trailing edge
            #100;
        end
        dt = ~dt; // Released line must not keep its last level
        #300;
    endtask
endmodule

// file: testbench/tb_top.sv
// Self-checking bench for the slave serial port: bus tasks, link master, verdict.
// Assumes the master model and the checker from the other bench files.
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rv;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, cpu_sleep = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
    logic        clock_pin_out, clock_pin_oe, data_pin_out, data_pin_oe, wake, irq;
    logic        ck, dt_drv;
    wire logic   clock_pin_in, data_pin_in;
    logic [11:0] isr_addr;
    logic [8:0]  q;
    int          mismatches = 0, check_count = 0;
    assign clock_pin_in = clock_pin_oe ? clock_pin_out : ck;
    assign data_pin_in = data_pin_oe ? data_pin_out : dt_drv;
    always #12.5 clk = ~clk;
    ssp_slave_port ssp_slave_port_inst (.clk, .srst, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .cpu_sleep, .clock_pin_in, .clock_pin_out, .clock_pin_oe, .data_pin_in,
        .data_pin_out, .data_pin_oe, .wake, .irq, .isr_addr);
    ssp_master_model ssp_master_model_inst (.pin(data_pin_in), .ck(ck), .dt(dt_drv));
    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h000000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input string nm, input logic [31:0] e);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        rv = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        chk(nm, rv, e);
    endtask
    task automatic link(input logic [8:0] d, input int n);
        ssp_master_model_inst.xfer(d, n, q);
    endtask
    initial begin
        #200000;
        mismatches++;
        summarize();
    end
    initial begin
        repeat (8) @(posedge clk);
        srst <= 1'b0;
        rd(ssp_pkg::OFS_IRQ, "flags at reset", 32'h10);
        rd(8'h18, "unmapped read", 32'h0);
        chk("unmapped read resp", {30'h0, resp}, 32'h2);
        wr(8'h18, 8'hff);
        chk("unmapped write resp", {30'h0, resp}, 32'h2);
        wr(ssp_pkg::OFS_RX_STATUS, 8'h80);
        wr(ssp_pkg::OFS_TX_STATUS, 8'h30);
        wr(ssp_pkg::OFS_TX_DATA, 8'ha5);
        wr(ssp_pkg::OFS_TX_DATA, 8'h3c);
        rd(ssp_pkg::OFS_IRQ, "flag queued", 32'h00);
        wr(ssp_pkg::OFS_IRQ, 8'h05);
        cpu_sleep <= 1'b1;
        repeat (2) @(posedge clk);
        chk("wake early", {31'h0, wake}, 32'h0);
        link(9'h000, 8);
        chk("first char", {23'h0, q}, 32'ha5);
        chk("wake irq", {30'h0, wake, irq}, 32'h2);
        link(9'h000, 8);
        chk("second char", {23'h0, q}, 32'h3c);
        wr(ssp_pkg::OFS_IRQ, 8'h0d);
        repeat (2) @(posedge clk);
        chk("vector", {20'h0, isr_addr}, 32'h004);
        wr(ssp_pkg::OFS_TX_DATA, 8'h11);
        wr(ssp_pkg::OFS_TX_DATA, 8'h22);
        rd(ssp_pkg::OFS_IRQ, "flag cleared", 32'h0d);
        wr(ssp_pkg::OFS_RX_STATUS, 8'h00);
        rd(ssp_pkg::OFS_IRQ, "port reset", 32'h1d);
        wr(ssp_pkg::OFS_RX_STATUS, 8'h80);
        wr(ssp_pkg::OFS_TX_STATUS, 8'h71);
        wr(ssp_pkg::OFS_TX_DATA, 8'h5a);
        link(9'h000, 9);
        chk("nine bit char", {23'h0, q}, 32'h15a);
        wr(ssp_pkg::OFS_IRQ, 8'h06);
        wr(ssp_pkg::OFS_TX_STATUS, 8'h10);
        wr(ssp_pkg::OFS_RX_STATUS, 8'he0);
        link(9'h1c3, 9);
        link(9'h055, 9);
        chk("rx wake", {31'h0, wake}, 32'h1);
        rd(ssp_pkg::OFS_RX_STATUS, "ninth top", 32'he1);
        rd(ssp_pkg::OFS_RX_DATA, "rx first", 32'hc3);
        rd(ssp_pkg::OFS_RX_STATUS, "ninth next", 32'he0);
        rd(ssp_pkg::OFS_RX_DATA, "rx second", 32'h55);
        rd(ssp_pkg::OFS_IRQ, "rx flag clear", 32'h16);
        wr(ssp_pkg::OFS_RX_STATUS, 8'h90);
        link(9'h081, 8);
        link(9'h042, 8);
        link(9'h024, 8);
        rd(ssp_pkg::OFS_RX_STATUS, "overrun", 32'h92);
        rd(ssp_pkg::OFS_RX_DATA, "kept first", 32'h81);
        wr(ssp_pkg::OFS_RX_STATUS, 8'h80);
        rd(ssp_pkg::OFS_RX_STATUS, "overrun clear", 32'h80);
        rd(ssp_pkg::OFS_RX_DATA, "kept second", 32'h42);
        wr(ssp_pkg::OFS_BAUD, 8'h10);
        ssp_master_model_inst.set_pol(1'b1);
        wr(ssp_pkg::OFS_TX_STATUS, 8'h30);
        wr(ssp_pkg::OFS_TX_DATA, 8'h96);
        link(9'h000, 8);
        chk("falling lead char", {23'h0, q}, 32'h96);
        rd(ssp_pkg::OFS_BAUD, "polarity idle", 32'h50);
        summarize();
    end
endmodule
bind ssp_slave_port ssp_slave_port_asserts ssp_slave_port_asserts_inst (.clk, .srst,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
    .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
    .s_axi_rready, .s_axi_rdata, .cpu_sleep, .clock_pin_oe, .wake, .irq, .isr_addr);
